// >>> design/lafl_pkg.sv
// package for the lifting-axle forced lowering block
// assumes a 40 MHz core clock; all counts derive from it
package lafl_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40000000;  // core clock rate
  localparam int unsigned PRESS_MS        = 5000;      // long press time in ms
  localparam int unsigned PRESS_CYC       = (CLK_HZ / 1000) * PRESS_MS;  // least time, exact
  localparam int unsigned DEBOUNCE_US     = 10;        // debounce settle time in us
  localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int unsigned PRESS_W         = 28;        // press counter width
  localparam int unsigned DEB_W           = 16;        // debounce counter width

  // ---------------------------------------------------------------
  // avalon register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS    = 4'h0;  // configuration
  localparam logic [3:0] PANEL_OFS   = 4'h4;  // display panel and remote requests
  localparam logic [3:0] STATUS_OFS  = 4'h8;  // block state, read only
  localparam logic [3:0] INPUTS_OFS  = 4'hc;  // debounced contacts and vehicle flags, read only

  // ctrl field positions
  localparam int unsigned CTRL_SRC_LSB   = 0;  // two-bit source select
  localparam int unsigned CTRL_POL_BIT   = 2;  // 1: input active at supply
  localparam int unsigned CTRL_SCOPE_BIT = 3;  // 1: second axle only
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

  // panel field positions
  localparam int unsigned PNL_LOWER_BIT  = 0;  // panel requests lowering
  localparam int unsigned PNL_OVR_BIT    = 1;  // panel value overrides switch
  localparam int unsigned PNL_AX1_BIT    = 2;  // keep axle 1 down
  localparam int unsigned PNL_AX2_BIT    = 3;  // keep axle 2 down
  localparam int unsigned PNL_REMOTE_BIT = 4;  // remote control lowering
  localparam logic [31:0] PANEL_RST      = 32'h0000_0000;

  // lowering source selection
  typedef enum logic [1:0] {
    SRC_SWITCH = 2'b00,
    SRC_BUTTON = 2'b01,
    SRC_REMOTE = 2'b10,
    SRC_PANEL  = 2'b11
  } lafl_src_t;

  // button press state machine
  typedef enum logic [1:0] {
    BTN_IDLE  = 2'b00,
    BTN_TIMED = 2'b01,
    BTN_HELD  = 2'b10
  } lafl_btn_t;

endpackage : lafl_pkg

// >>> design/lafl_debounce.sv
// two-flop synchroniser and settle-time debouncer for one input
// assumes the input is a slow mechanical contact
`timescale 1ns/100ps
`default_nettype none
module lafl_debounce
  import lafl_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // raw and filtered level
  input  wire logic raw_in,
  output var  logic clean_ff
);

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  logic              meta_ff;  // first stage, read only by sync_ff
  logic              sync_ff;  // second stage
  logic [DEB_W-1:0]  cnt_ff;   // settle counter

  // bound for the settle check, one above the counter limit
  localparam int     SETTLE_MAX = DEBOUNCE_CYC;

  // two-flop crossing of the raw contact
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // debounce: a change must stand for the settle time
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff   <= '0;
      clean_ff <= 1'b0;
    end else if (sync_ff == clean_ff) begin
      cnt_ff <= '0;                                      // no change pending
    end else if (cnt_ff == DEB_W'(DEBOUNCE_CYC - 1)) begin
      cnt_ff   <= '0;
      clean_ff <= sync_ff;                               // change accepted
    end else begin
      cnt_ff <= cnt_ff + DEB_W'(1);
    end
  end

  // a lasting change must reach the output in bounded time
  AST_DEB_SETTLE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sync_ff != clean_ff) [*8] |-> ##[0:SETTLE_MAX] (sync_ff == clean_ff) || $changed(sync_ff))
    else $error("debounced level did not follow input");

endmodule : lafl_debounce
`default_nettype wire

// >>> design/lafl_top.sv
// forced lowering and deactivation of the lifting-axle function
// assumes avalon-mm master on the register side and contact inputs on pins
// How it works
// - lowering request suspends automatic axle raising
// - closed switch lowers every lifting axle
// - display panel overrides disagreeing switch input
// - opened switch returns control to automatic
// - button held over five seconds lowers axles
// - shorter press re-enables automatic control
// - two axles individually held down
// - one axle held lets other rise
// - rear axle lowering inhibits load and turning
// - front axle deactivation inhibits traction help
// - raise only within speed and pressure limits
// - input polarity selectable supply or ground
// - lowering acts on all or second axle
// - source select: switch button remote panel
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lafl_top
  import lafl_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // contact inputs from the towing vehicle
  input  wire logic        lower_in,
  input  wire logic        axle1_sw_in,
  input  wire logic        axle2_sw_in,
  // vehicle state flags
  input  wire logic        speed_ok,
  input  wire logic        pressure_ok,
  // automatic control requests from the level logic
  input  wire logic        auto_raise1,
  input  wire logic        auto_raise2,
  // axle and function commands
  output var  logic        axle1_raise_ff,
  output var  logic        axle2_raise_ff,
  output var  logic        auto_suspend_ff,
  output var  logic        load_opt_inhibit_ff,
  output var  logic        turn_assist_inhibit_ff,
  output var  logic        traction_inhibit_ff
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]        ctrl_ff;        // configuration register
  logic [31:0]        panel_ff;       // panel and remote register
  logic               rd_done_ff;     // read answer cycle
  logic               lower_clean;    // debounced lowering contact
  logic               ax1_clean;      // debounced axle 1 switch
  logic               ax2_clean;      // debounced axle 2 switch
  logic               lower_act;      // polarity-corrected request
  lafl_src_t          src;            // selected source
  lafl_btn_t          btn_ff;         // button state
  logic [PRESS_W-1:0] press_ff;       // press duration counter
  logic               btn_lower_ff;   // latched long-press lowering
  logic               force_req;      // forced lowering request of the selected source
  logic               hold1;          // axle 1 held down
  logic               hold2;          // axle 2 held down
  logic               limits_ok;      // raising permitted by flags
  logic               wr_hit;         // accepted write
  logic [31:0]        be_mask;        // byte lane mask

  // ---------------------------------------------------------------
  // input filtering
  // ---------------------------------------------------------------
  // one filter per contact; mechanical bounce would restart the press timer
  lafl_debounce u_deb_lower (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .raw_in   (lower_in),
    .clean_ff (lower_clean)
  );

  lafl_debounce u_deb_ax1 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .raw_in   (axle1_sw_in),
    .clean_ff (ax1_clean)
  );

  lafl_debounce u_deb_ax2 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .raw_in   (axle2_sw_in),
    .clean_ff (ax2_clean)
  );

  // ---------------------------------------------------------------
  // avalon slave
  // ---------------------------------------------------------------
  // writes finish at once; reads wait one cycle for registered data
  assign avs_waitrequest = avs_read && !rd_done_ff;
  assign wr_hit          = avs_write;
  assign be_mask         = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // read answer strobe, cleared once the master takes the data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_done_ff <= 1'b0;
    end else begin
      rd_done_ff <= avs_read && !rd_done_ff;
    end
  end

  // read data register; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_done_ff) begin
      case (avs_address)
        CTRL_OFS:   avs_readdata <= {28'h0000000, ctrl_ff[3:0]};
        PANEL_OFS:  avs_readdata <= {27'h0000000, panel_ff[4:0]};
        STATUS_OFS: avs_readdata <= {24'h000000, btn_lower_ff, force_req,
                                     traction_inhibit_ff, load_opt_inhibit_ff,
                                     auto_suspend_ff, axle2_raise_ff,
                                     axle1_raise_ff, btn_ff == BTN_TIMED};
        INPUTS_OFS: avs_readdata <= {27'h0000000, pressure_ok, speed_ok,
                                     ax2_clean, ax1_clean, lower_clean};
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration register: source, polarity, scope
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_hit && avs_address == CTRL_OFS) begin
      ctrl_ff <= (ctrl_ff & ~be_mask) | (avs_writedata & be_mask & 32'h0000_000f);
    end
  end

  // panel register: display panel and remote control requests
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      panel_ff <= PANEL_RST;
    end else if (wr_hit && avs_address == PANEL_OFS) begin
      panel_ff <= (panel_ff & ~be_mask) | (avs_writedata & be_mask & 32'h0000_001f);
    end
  end

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  // polarity: bit set means the contact is active when driven to supply
  assign lower_act = ctrl_ff[CTRL_POL_BIT] ? lower_clean : !lower_clean;
  assign src       = lafl_src_t'(ctrl_ff[CTRL_SRC_LSB +: 2]);
  assign limits_ok = speed_ok && pressure_ok;

  // source priority; the panel wins over the switch when it overrides
  always_comb begin
    case (src)
      SRC_SWITCH: begin
        if (panel_ff[PNL_OVR_BIT]) begin
          force_req = panel_ff[PNL_LOWER_BIT];
        end else begin
          force_req = lower_act;
        end
      end
      SRC_BUTTON: force_req = btn_lower_ff || panel_ff[PNL_LOWER_BIT];
      SRC_REMOTE: force_req = panel_ff[PNL_REMOTE_BIT];
      SRC_PANEL:  force_req = panel_ff[PNL_LOWER_BIT];
      default:    force_req = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // button timing
  // ---------------------------------------------------------------
  // a press that ends early toggles nothing; it only clears a held lowering
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      btn_ff       <= BTN_IDLE;
      press_ff     <= '0;
      btn_lower_ff <= 1'b0;
    end else if (src != SRC_BUTTON) begin
      btn_ff       <= BTN_IDLE;
      press_ff     <= '0;
      btn_lower_ff <= 1'b0;
    end else begin
      case (btn_ff)
        BTN_IDLE: begin
          press_ff <= '0;
          if (lower_act) begin
            btn_ff <= BTN_TIMED;
          end
        end
        BTN_TIMED: begin
          if (!lower_act) begin
            btn_ff       <= BTN_IDLE;
            btn_lower_ff <= 1'b0;
          end else if (press_ff == PRESS_W'(PRESS_CYC)) begin
            btn_ff       <= BTN_HELD;
            btn_lower_ff <= 1'b1;
          end else begin
            press_ff <= press_ff + PRESS_W'(1);
          end
        end
        BTN_HELD: begin
          // lowering stays latched after release until the next short press or a change of source away from SRC_BUTTON
          if (!lower_act) begin
            btn_ff <= BTN_IDLE;
          end
        end
        default: btn_ff <= BTN_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axle holding
  // ---------------------------------------------------------------
  // forced lowering reaches axle 1 only when scope is all axles
  assign hold1 = (force_req && !ctrl_ff[CTRL_SCOPE_BIT])
               || ax1_clean || panel_ff[PNL_AX1_BIT];
  assign hold2 = force_req || ax2_clean || panel_ff[PNL_AX2_BIT];

  // ---------------------------------------------------------------
  // axle commands
  // ---------------------------------------------------------------
  // a held axle never rises; the free one still follows automatic control
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      axle1_raise_ff <= 1'b0;
      axle2_raise_ff <= 1'b0;
    end else begin
      axle1_raise_ff <= auto_raise1 && !hold1 && limits_ok;
      axle2_raise_ff <= auto_raise2 && !hold2 && limits_ok;
    end
  end

  // automatic suspension flag shows a forced lowering in force
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_suspend_ff <= 1'b0;
    end else begin
      auto_suspend_ff <= force_req;
    end
  end

  // ---------------------------------------------------------------
  // dependent function inhibits
  // ---------------------------------------------------------------
  // axle 2 is the rear axle, axle 1 the front; inhibits follow the hold
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_opt_inhibit_ff    <= 1'b0;
      turn_assist_inhibit_ff <= 1'b0;
      traction_inhibit_ff    <= 1'b0;
    end else begin
      load_opt_inhibit_ff    <= hold2;
      turn_assist_inhibit_ff <= hold2;
      traction_inhibit_ff    <= hold1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_long_press;
    (src == SRC_BUTTON && btn_ff == BTN_TIMED && press_ff == PRESS_W'(PRESS_CYC) && lower_act);
  endsequence

  AST_SUSPEND: assert property (@(posedge core_clk) disable iff (!reset_n)
    force_req |=> auto_suspend_ff)
    else $error("suspend flag missing during lowering");

  AST_SWITCH_LOWER: assert property (@(posedge core_clk) disable iff (!reset_n)
    (src == SRC_SWITCH && !panel_ff[PNL_OVR_BIT] && lower_act && !ctrl_ff[CTRL_SCOPE_BIT])
      |=> !axle1_raise_ff && !axle2_raise_ff)
    else $error("switch closed but an axle rises");

  AST_PANEL_PRIO: assert property (@(posedge core_clk) disable iff (!reset_n)
    (src == SRC_SWITCH && panel_ff[PNL_OVR_BIT]) |-> force_req == panel_ff[PNL_LOWER_BIT])
    else $error("panel did not override switch");

  AST_SWITCH_OPEN: assert property (@(posedge core_clk) disable iff (!reset_n)
    (src == SRC_SWITCH && !panel_ff[PNL_OVR_BIT] && !lower_act) |=> !auto_suspend_ff)
    else $error("open switch kept automatic control off");

  AST_LONG_PRESS: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_long_press |=> btn_lower_ff && btn_ff == BTN_HELD)
    else $error("long press did not lower");

  AST_NO_EARLY: assert property (@(posedge core_clk) disable iff (!reset_n)
    (btn_ff == BTN_IDLE && !btn_lower_ff) |=> !btn_lower_ff)
    else $error("lowering latched without timed press");

  AST_SHORT_PRESS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (src == SRC_BUTTON && btn_ff == BTN_TIMED && !lower_act) |=> !btn_lower_ff)
    else $error("short press did not restore automatic");

  AST_AXLE_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ax1_clean || panel_ff[PNL_AX1_BIT]) |=> !axle1_raise_ff)
    else $error("held axle 1 raised");

  AST_OTHER_RISES: assert property (@(posedge core_clk) disable iff (!reset_n)
    (hold1 && !hold2 && auto_raise2 && limits_ok) |=> axle2_raise_ff)
    else $error("free axle not raised");

  AST_REAR_INHIBIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    hold2 |=> load_opt_inhibit_ff && turn_assist_inhibit_ff)
    else $error("rear lowering left functions on");

  AST_FRONT_INHIBIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    hold1 |=> traction_inhibit_ff)
    else $error("front deactivation left traction help on");

  AST_LIMITS: assert property (@(posedge core_clk) disable iff (!reset_n)
    !limits_ok |=> !axle1_raise_ff && !axle2_raise_ff)
    else $error("axle raised outside limits");

  AST_POLARITY: assert property (@(posedge core_clk) disable iff (!reset_n)
    lower_act == (lower_clean ~^ ctrl_ff[CTRL_POL_BIT]))
    else $error("input polarity wrong");

  AST_SCOPE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_ff[CTRL_SCOPE_BIT] && force_req && !ax1_clean && !panel_ff[PNL_AX1_BIT]
     && auto_raise1 && limits_ok) |=> axle1_raise_ff)
    else $error("second-axle scope lowered axle 1");

  AST_REMOTE_SRC: assert property (@(posedge core_clk) disable iff (!reset_n)
    (src == SRC_REMOTE) |-> force_req == panel_ff[PNL_REMOTE_BIT])
    else $error("remote source not honoured");

endmodule : lafl_top
`default_nettype wire

// >>> test/lafl_contact_model.sv
// driver-side contacts: lowering switch or button and two hold switches
// assumes the bench says pressed or not; wiring level follows the polarity
`timescale 1ns/100ps
`default_nettype none
module lafl_contact_model (
  // clock
  input  wire logic core_clk,
  // operator actions and wiring choice
  input  wire logic pol,
  input  wire logic press,
  input  wire logic hold1,
  input  wire logic hold2,
  // contact levels at the pins
  output var  logic lower_in,
  output var  logic axle1_sw_in,
  output var  logic axle2_sw_in
);
  // released contact with grounded wiring sits high, so start inactive
  initial begin
    lower_in    = 1'b1;
    axle1_sw_in = 1'b0;
    axle2_sw_in = 1'b0;
  end
  // pressed means supply with pol set, ground otherwise
  always @(posedge core_clk) begin
    lower_in    <= pol ? press : !press;
    axle1_sw_in <= hold1;
    axle2_sw_in <= hold2;
  end
endmodule : lafl_contact_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the forced lowering block
// assumes package timing; the five second press is out of reach
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lafl_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0, reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic pol = 1'b0, press = 1'b0, hold1 = 1'b0, hold2 = 1'b0;
  logic lower_in, axle1_sw_in, axle2_sw_in;
  logic speed_ok = 1'b1, pressure_ok = 1'b1, auto_raise1 = 1'b1, auto_raise2 = 1'b1;
  logic a1, a2, susp, lo, ta, tr;
  int error_cnt = 0, compares = 0;
  // row: ctrl, panel, {press,hold1,hold2}, {speed,pressure,auto1,auto2}, expected outputs
  logic [21:0] rows [14] = '{
    {4'h0, 5'h00, 3'b000, 4'hf, 6'b110000},
    {4'h0, 5'h00, 3'b100, 4'hf, 6'b001111},
    {4'h0, 5'h02, 3'b100, 4'hf, 6'b110000},
    {4'h0, 5'h03, 3'b000, 4'hf, 6'b001111},
    {4'h8, 5'h00, 3'b100, 4'hf, 6'b101110},
    {4'h0, 5'h00, 3'b010, 4'hf, 6'b010001},
    {4'h0, 5'h08, 3'b000, 4'hf, 6'b100110},
    {4'h0, 5'h00, 3'b000, 4'h7, 6'b000000},
    {4'h0, 5'h00, 3'b000, 4'hb, 6'b000000},
    {4'h4, 5'h00, 3'b100, 4'hf, 6'b001111},
    {4'h2, 5'h10, 3'b000, 4'hf, 6'b001111},
    {4'h3, 5'h01, 3'b000, 4'hf, 6'b001111},
    {4'h2, 5'h00, 3'b100, 4'hf, 6'b110000},
    {4'h0, 5'h00, 3'b001, 4'hc, 6'b000110}
  };
  // free-running core clock, 25 ns period
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  lafl_contact_model drv (.core_clk(core_clk), .pol(pol), .press(press), .hold1(hold1), .hold2(hold2),
    .lower_in(lower_in), .axle1_sw_in(axle1_sw_in), .axle2_sw_in(axle2_sw_in));
  lafl_top uut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lower_in(lower_in),
    .axle1_sw_in(axle1_sw_in), .axle2_sw_in(axle2_sw_in), .speed_ok(speed_ok), .pressure_ok(pressure_ok),
    .auto_raise1(auto_raise1), .auto_raise2(auto_raise2), .axle1_raise_ff(a1), .axle2_raise_ff(a2),
    .auto_suspend_ff(susp), .load_opt_inhibit_ff(lo), .turn_assist_inhibit_ff(ta), .traction_inhibit_ff(tr));
  // verdict and end of run
  task automatic summarize();
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // output vector compare
  task automatic chk_out(input string nm, input logic [5:0] exp);
    compares++;
    if ({a1, a2, susp, lo, ta, tr} !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, exp, {a1, a2, susp, lo, ta, tr});
    end
  endtask : chk_out
  // register value compare
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_reg
  // one bus cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
  endtask : bus
  // long enough for sync plus the 400-cycle debounce and output update
  task automatic settle();
    repeat (450) @(posedge core_clk);
  endtask : settle
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    chk_out("reset_outputs", 6'b000000);
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h0);
    chk_reg("ctrl_reset", CTRL_RST, rd);
    bus(1'b0, PANEL_OFS, 32'h0);
    chk_reg("panel_reset", PANEL_RST, rd);
    bus(1'b1, CTRL_OFS, 32'hffff_ffff);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk_reg("ctrl_reserved", 32'h0000_000f, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk_reg("unmapped_read", 32'h0, rd);
    // table of ordinary cases
    foreach (rows[i]) begin
      bus(1'b1, CTRL_OFS, {28'h0, rows[i][21:18]});
      bus(1'b1, PANEL_OFS, {27'h0, rows[i][17:13]});
      pol <= rows[i][20];
      {press, hold1, hold2} <= rows[i][12:10];
      {speed_ok, pressure_ok, auto_raise1, auto_raise2} <= rows[i][9:6];
      settle();
      chk_out($sformatf("row%0d", i), rows[i][5:0]);
    end
    // filtered contacts and flags as left by the last row
    bus(1'b0, INPUTS_OFS, 32'h0);
    chk_reg("inputs", 32'h0000_001d, rd);
    // short button press latches no lowering; automatic control stays on
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b1, PANEL_OFS, 32'h0);
    {speed_ok, pressure_ok, auto_raise1, auto_raise2} <= 4'hf;
    {pol, press, hold1, hold2} <= 4'b0100;
    settle();
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_reg("press_timing", 32'h1, rd & 32'h1);
    chk_out("press_early", 6'b110000);
    press <= 1'b0;
    settle();
    chk_out("short_press", 6'b110000);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_reg("no_latch", 32'h0, rd & 32'h81);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
